/* File: core/pm_capability.sv */
/*
 Power management capability and control/status registers of the
 legacy host controller function, reached by configuration cycles.
 Assumes config requests and resume status come from clk_sys logic.
*/
// Overview of operation
// R1: Version field bits 2:0 read 010.
// R2: Wake-clock bit 3 reads zero; wake needs no bus clock.
// R3: Special-initialisation bit 5 reads zero.
// R4: Without cold-state wake support, auxiliary current bits 8:6 read 000.
// R5: With cold-state wake, auxiliary current field encodes supply draw.
// R6: Bits 9 and 10 read one: D1 and D2 supported.
// R7: Bits 14:11 read 1111: wake from D0, D1, D2, D3hot.
// R8: Bit 15 shows cold-state wake support, default zero, overwritable.
// R9: Overwritable fields take writes only while overwrite enable is one.
// R10: With a serial ROM, load those fields before accepting config access; the first access is taken at the edge that stores the ROM byte.
// R11: Power state bits 1:0 report and take the state: D0..D3hot.
// R12: Control bits 14:9 and 7:2 read zero.
// R13: Wake enable bit 8 gates the wake signal; resets to zero.
// R14: With cold-state support, enable and flag survive reset.
// R15: Wake flag bit 15 sets on resume detection, regardless of enable.
// R16: Writing one to the wake flag clears it; zero leaves it.
// R17: Any state other than D0 means global suspend, clock stopped.
// R18: Wake signal active while flag and enable are both one.
`timescale 1ns/1ps
module pm_capability
  import pm_cap_pkg::*;
#(
  parameter int QUARTER = I2C_QUARTER_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  output logic cfgRetry,
  output logic cfgAck,
  output logic [31:0] cfgReadData,
  input wire logic identOverwriteEnable,
  input wire logic resumeSeenFlag,
  output logic wakeSignalOut,
  output logic globalSuspend,
  input wire logic romPresentPin,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  typedef struct packed {
    logic [2:0] auxCurrent;
    logic coldWake;
    pstate_type powerState;
    logic wakeEnable;
    logic wakeFlag;
    logic resumePrev;
    logic holdWake;
    logic ack;
    logic [31:0] readData;
    logic wakeOut;
    logic suspend;
  } bank_type;

  rom_load_if rom ();

  i2c_rom_loader #(
    .QUARTER(QUARTER)
  ) u_loader (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .romPresentPin(romPresentPin),
    .sdaIn(sdaIn),
    .sclOe(sclOe),
    .sdaOe(sdaOe),
    .rom(rom.loader)
  );

  bank_type s_ff;
  bank_type nxt_s;
  logic taken;
  logic wrCap;
  logic wrCtrl;
  logic rdCap;
  logic rdCtrl;
  logic resumeRise;
  logic flagClear;
  logic [15:0] capWord;
  logic [15:0] ctrlWord;
  logic [2:0] auxShown;

  // Open-drain pins only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  // Config access waits until the ROM load has finished
  assign cfgRetry = cfgReq && !rom.loadDone; // [R10]
  assign taken = cfgReq && rom.loadDone; // [R10]
  assign rdCap = taken && cfgAddr[7:2] == CAP_DWORD_IDX;
  assign rdCtrl = taken && cfgAddr[7:2] == CTRL_DWORD_IDX;
  assign wrCap = rdCap && cfgWrite && identOverwriteEnable; // [R9]
  assign wrCtrl = rdCtrl && cfgWrite;
  assign resumeRise = resumeSeenFlag && !s_ff.resumePrev;
  assign flagClear = wrCtrl && cfgByteEn[1]
    && cfgWriteData[WAKE_FLAG_BIT];

  // Aux current field is meaningful only with cold-state wake
  assign auxShown = s_ff.coldWake ? s_ff.auxCurrent : 3'h0; // [R4] [R5]

  always_comb begin
    capWord = '0;
    capWord[VERSION_LSB +: 3] = VERSION_VAL; // [R1]
    capWord[WAKE_CLK_BIT] = 1'b0; // [R2]
    capWord[DSI_BIT] = 1'b0; // [R3]
    capWord[AUX_LSB +: 3] = auxShown; // [R4]
    capWord[ONE_SUP_BIT] = 1'b1; // [R6]
    capWord[TWO_SUP_BIT] = 1'b1; // [R6]
    capWord[WAKE_STATES_LSB +: 4] = WAKE_STATES_VAL; // [R7]
    capWord[COLD_BIT] = s_ff.coldWake; // [R8]
  end

  always_comb begin
    ctrlWord = '0; // [R12]
    ctrlWord[PSTATE_LSB +: 2] = s_ff.powerState; // [R11]
    ctrlWord[WAKE_EN_BIT] = s_ff.wakeEnable;
    ctrlWord[WAKE_FLAG_BIT] = s_ff.wakeFlag;
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = taken;
    nxt_s.resumePrev = resumeSeenFlag;
    nxt_s.holdWake = 1'b0;
    if (rdCap) begin
      nxt_s.readData = {capWord, NEXT_PTR, CAP_ID};
    end else if (rdCtrl) begin
      nxt_s.readData = {16'h0000, ctrlWord};
    end else if (taken) begin
      nxt_s.readData = 32'h0000_0000;
    end
    // Serial ROM contents replace the overwritable defaults
    if (rom.loadStrobe) begin
      nxt_s.auxCurrent = rom.loadByte[ROM_AUX_LSB +: 3]; // [R10]
      nxt_s.coldWake = rom.loadByte[ROM_COLD_BIT]; // [R10]
    end
    if (wrCap && cfgByteEn[2]) begin
      nxt_s.auxCurrent[1:0] =
        cfgWriteData[PMC_SHIFT + AUX_LSB +: 2]; // [R9]
    end
    if (wrCap && cfgByteEn[3]) begin
      nxt_s.auxCurrent[2] =
        cfgWriteData[PMC_SHIFT + AUX_LSB + 2]; // [R9]
      nxt_s.coldWake = cfgWriteData[PMC_SHIFT + COLD_BIT]; // [R8] [R9]
    end
    if (wrCtrl && cfgByteEn[0]) begin
      nxt_s.powerState =
        pstate_type'(cfgWriteData[PSTATE_LSB +: 2]); // [R11]
    end
    if (wrCtrl && cfgByteEn[1]) begin
      nxt_s.wakeEnable = cfgWriteData[WAKE_EN_BIT]; // [R13]
    end
    // A resume edge in the clearing cycle keeps the flag set
    if (resumeRise) begin
      nxt_s.wakeFlag = 1'b1; // [R15]
    end else if (flagClear) begin
      nxt_s.wakeFlag = 1'b0; // [R16]
    end
    nxt_s.wakeOut = nxt_s.wakeFlag && nxt_s.wakeEnable; // [R18] [R13]
    nxt_s.suspend = nxt_s.powerState != PS_D0; // [R17]
    if (!reset_n) begin
      nxt_s = '0;
      nxt_s.auxCurrent = AUX_RESET;
      nxt_s.coldWake = COLD_RESET; // [R8]
      nxt_s.powerState = PS_D0;
      nxt_s.resumePrev = 1'b1;
      // Cold-wake choice is remembered for the whole reset, not its first edge
      nxt_s.holdWake = s_ff.coldWake || s_ff.holdWake; // [R14]
      // Wake bits are kept across reset when cold-state wake is on
      if (s_ff.coldWake || s_ff.holdWake) begin
        nxt_s.wakeEnable = s_ff.wakeEnable; // [R14]
        nxt_s.wakeFlag = s_ff.wakeFlag; // [R14]
        nxt_s.wakeOut = s_ff.wakeOut; // [R14]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    s_ff <= nxt_s;
  end

  assign cfgAck = s_ff.ack;
  assign cfgReadData = s_ff.readData;
  assign wakeSignalOut = s_ff.wakeOut;
  assign globalSuspend = s_ff.suspend;

  a_fixed_caps: assert property ( // [R1] [R2] [R3] [R6] [R7]
    @(posedge clk_sys) disable iff (!reset_n)
    cfgAck && $past(rdCap) |->
      cfgReadData[PMC_SHIFT +: 6] == 6'h02
      && cfgReadData[PMC_SHIFT + 9 +: 6] == 6'h3f)
    else $error("fixed capability bits wrong");

  a_aux_zero: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!reset_n)
    cfgAck && $past(rdCap) && !cfgReadData[PMC_SHIFT + COLD_BIT] |->
      cfgReadData[PMC_SHIFT + AUX_LSB +: 3] == 3'h0)
    else $error("aux current not zero without cold wake");

  a_overwrite_lock: assert property ( // [R9]
    @(posedge clk_sys) disable iff (!reset_n)
    rdCap && cfgWrite && !identOverwriteEnable && !rom.loadStrobe
      |=> $stable(s_ff.coldWake) && $stable(s_ff.auxCurrent))
    else $error("locked capability field changed");

  a_load_first: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    !rom.loadDone |=> !cfgAck)
    else $error("config answered before ROM load");

  a_ctrl_zero: assert property ( // [R12]
    @(posedge clk_sys) disable iff (!reset_n)
    cfgAck && $past(rdCtrl) |->
      cfgReadData[14:9] == 6'h00 && cfgReadData[7:2] == 6'h00)
    else $error("control reserved bits not zero");

  a_pstate_write: assert property ( // [R11] [R17]
    @(posedge clk_sys) disable iff (!reset_n)
    wrCtrl && cfgByteEn[0] |=>
      s_ff.powerState == $past(cfgWriteData[1:0])
      && globalSuspend == ($past(cfgWriteData[1:0]) != 2'h0))
    else $error("power state write not applied");

  a_flag_set: assert property ( // [R15]
    @(posedge clk_sys) disable iff (!reset_n)
    resumeSeenFlag && !s_ff.resumePrev |=> s_ff.wakeFlag)
    else $error("resume did not set wake flag");

  a_flag_clear: assert property ( // [R16]
    @(posedge clk_sys) disable iff (!reset_n)
    flagClear && !resumeRise |=> !s_ff.wakeFlag)
    else $error("write one did not clear wake flag");

  a_flag_zero_write: assert property ( // [R16]
    @(posedge clk_sys) disable iff (!reset_n)
    wrCtrl && !cfgWriteData[WAKE_FLAG_BIT] && s_ff.wakeFlag
      |=> s_ff.wakeFlag)
    else $error("write zero cleared wake flag");

  a_wake_gate: assert property ( // [R13] [R18]
    @(posedge clk_sys) disable iff (!reset_n)
    wakeSignalOut == (s_ff.wakeFlag && s_ff.wakeEnable))
    else $error("wake output does not follow flag and enable");

  a_sticky_reset: assert property ( // [R14]
    @(posedge clk_sys)
    !reset_n && (s_ff.coldWake || s_ff.holdWake)
      |=> $stable(s_ff.wakeFlag) && $stable(s_ff.wakeEnable))
    else $error("sticky wake bits lost in reset");

  a_reset_clears_wake: assert property ( // [R13] [R14]
    @(posedge clk_sys)
    !reset_n && !s_ff.coldWake && !s_ff.holdWake
      |=> !s_ff.wakeEnable && !s_ff.wakeFlag && !wakeSignalOut)
    else $error("wake bits kept in reset without cold wake");

  a_reset_values: assert property ( // [R11] [R17]
    @(posedge clk_sys)
    !reset_n |=> !cfgAck && !globalSuspend && s_ff.powerState == PS_D0
      && cfgReadData == 32'h0000_0000)
    else $error("reset values wrong");

  // Handshake of the configuration port and the serial ROM load
  a_ack_given: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    taken |=> cfgAck)
    else $error("taken request not acknowledged");

  a_ack_idle: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    !taken |=> !cfgAck)
    else $error("acknowledge without a taken request");

  a_retry_wait: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    cfgReq && !rom.loadDone |-> cfgRetry && !taken)
    else $error("request not retried during ROM load");

  a_pins_released: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    rom.loadDone |-> !sclOe && !sdaOe)
    else $error("serial ROM lines held after load");

  a_rom_applied: assert property ( // [R10]
    @(posedge clk_sys) disable iff (!reset_n)
    rom.loadStrobe && !wrCap |=>
      s_ff.coldWake == $past(rom.loadByte[ROM_COLD_BIT])
      && s_ff.auxCurrent == $past(rom.loadByte[ROM_AUX_LSB +: 3]))
    else $error("ROM byte not applied");

  // Read data of both dwords and of unmapped addresses
  a_cap_header: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    cfgAck && $past(rdCap) |-> cfgReadData[15:0] == {NEXT_PTR, CAP_ID})
    else $error("capability header wrong");

  a_ctrl_read: assert property ( // [R11] [R13] [R15]
    @(posedge clk_sys) disable iff (!reset_n)
    cfgAck && $past(rdCtrl) |->
      cfgReadData == {16'h0000, $past(ctrlWord)})
    else $error("control read data wrong");

  a_unmapped_zero: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    cfgAck && $past(!rdCap && !rdCtrl) |-> cfgReadData == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Register updates and their absence
  a_cap_unlocked: assert property ( // [R8] [R9]
    @(posedge clk_sys) disable iff (!reset_n)
    wrCap && cfgByteEn[3] |=>
      s_ff.coldWake == $past(cfgWriteData[PMC_SHIFT + COLD_BIT]))
    else $error("unlocked capability write lost");

  a_enable_write: assert property ( // [R13]
    @(posedge clk_sys) disable iff (!reset_n)
    wrCtrl && cfgByteEn[1] |=>
      s_ff.wakeEnable == $past(cfgWriteData[WAKE_EN_BIT]))
    else $error("wake enable write not applied");

  a_state_hold: assert property ( // [R11]
    @(posedge clk_sys) disable iff (!reset_n)
    !(wrCtrl && cfgByteEn[0]) |=> $stable(s_ff.powerState))
    else $error("power state changed without a write");

  a_read_no_change: assert property ( // [R11] [R13]
    @(posedge clk_sys) disable iff (!reset_n)
    taken && !cfgWrite |=> $stable(s_ff.powerState) && $stable(s_ff.wakeEnable))
    else $error("read changed control state");

  a_flag_hold: assert property ( // [R15] [R16]
    @(posedge clk_sys) disable iff (!reset_n)
    !resumeRise && !flagClear |=> $stable(s_ff.wakeFlag))
    else $error("wake flag changed without cause");

endmodule

/* File: core/pm_cap_pkg.sv */
/*
 Constants and types of the power management capability block.
 Assumes a 100 MHz clk_sys and a byte-addressed config window.
*/
package pm_cap_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int I2C_BIT_TIME_NS = 10000;
  // Least quarter-bit time, rounded up
  localparam int I2C_QUARTER_CYC =
    (I2C_BIT_TIME_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] CAP_DWORD_IDX = 6'h10;
  localparam logic [5:0] CTRL_DWORD_IDX = 6'h11;
  localparam logic [7:0] CAP_ID = 8'h01;
  localparam logic [7:0] NEXT_PTR = 8'h00;
  localparam int PMC_SHIFT = 16;
  localparam logic [2:0] VERSION_VAL = 3'h2;
  localparam int VERSION_LSB = 0;
  localparam int WAKE_CLK_BIT = 3;
  localparam int DSI_BIT = 5;
  localparam int AUX_LSB = 6;
  localparam int ONE_SUP_BIT = 9;
  localparam int TWO_SUP_BIT = 10;
  localparam int WAKE_STATES_LSB = 11;
  localparam int COLD_BIT = 15;
  localparam logic [3:0] WAKE_STATES_VAL = 4'hf;
  localparam logic [2:0] AUX_RESET = 3'h0;
  localparam logic COLD_RESET = 1'b0;
  localparam int PSTATE_LSB = 0;
  localparam int WAKE_EN_BIT = 8;
  localparam int WAKE_FLAG_BIT = 15;
  localparam logic [6:0] ROM_DEV_ADDR = 7'h50;
  localparam int ROM_AUX_LSB = 0;
  localparam int ROM_COLD_BIT = 7;
  typedef enum logic [1:0] {
    PS_D0 = 2'h0,
    PS_D1 = 2'h1,
    PS_D2 = 2'h2,
    PS_D3HOT = 2'h3
  } pstate_type;
endpackage

/* File: core/rom_load_if.sv */
/*
 Carries the values fetched from the serial ROM to the register bank.
 Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
interface rom_load_if;
  logic loadDone;
  logic loadStrobe;
  logic [7:0] loadByte;
  modport loader (output loadDone, output loadStrobe, output loadByte);
  modport bank (input loadDone, input loadStrobe, input loadByte);
endinterface

/* File: core/i2c_rom_loader.sv */
/*
 Serial ROM loader: one current-address read of one byte over I2C.
 Assumes open-drain SCL/SDA with pull-ups; no clock stretching.
*/
`timescale 1ns/1ps
module i2c_rom_loader
  import pm_cap_pkg::*;
#(
  parameter int QUARTER = I2C_QUARTER_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic romPresentPin,
  input wire logic sdaIn,
  output logic sclOe,
  output logic sdaOe,
  rom_load_if.loader rom
);
  typedef enum logic [4:0] {
    ST_STRAP = 5'h01,
    ST_START = 5'h02,
    ST_BITS = 5'h04,
    ST_STOP = 5'h08,
    ST_DONE = 5'h10
  } ld_state_type;
  typedef struct packed {
    ld_state_type st;
    logic [8:0] qCnt;
    logic [1:0] phase;
    logic [4:0] slot;
    logic [7:0] shift;
    logic abort;
    logic romMeta;
    logic romSync;
    logic sdaMeta;
    logic sdaSync;
    logic sclOe;
    logic sdaOe;
    logic done;
    logic strobe;
  } ld_type;
  localparam logic [7:0] ADDR_RD = {ROM_DEV_ADDR, 1'b1};
  ld_type s_ff;
  ld_type nxt_s;
  logic tick;
  logic [7:0] addrBits;
  always_comb begin
    nxt_s = s_ff;
    nxt_s.strobe = 1'b0;
    nxt_s.romMeta = romPresentPin;
    nxt_s.romSync = s_ff.romMeta;
    nxt_s.sdaMeta = sdaIn;
    nxt_s.sdaSync = s_ff.sdaMeta;
    tick = s_ff.qCnt == 9'(QUARTER - 1);
    nxt_s.qCnt = tick ? 9'h000 : 9'(s_ff.qCnt + 9'h001);
    addrBits = ADDR_RD << s_ff.slot[2:0];
    if (tick && s_ff.st != ST_DONE) begin
      nxt_s.phase = 2'(s_ff.phase + 2'h1);
      case (s_ff.st)
        ST_STRAP: begin
          nxt_s.phase = 2'h0;
          nxt_s.st = s_ff.romSync ? ST_START : ST_DONE;
          nxt_s.done = !s_ff.romSync;
        end
        ST_START: begin
          if (s_ff.phase == 2'h1) nxt_s.sdaOe = 1'b1;
          if (s_ff.phase == 2'h2) nxt_s.sclOe = 1'b1;
          if (s_ff.phase == 2'h3) nxt_s.st = ST_BITS;
        end
        ST_BITS: begin
          case (s_ff.phase)
            2'h0: nxt_s.sdaOe = (s_ff.slot < 5'h08) && !addrBits[7];
            2'h1: nxt_s.sclOe = 1'b0;
            2'h2: begin
              if (s_ff.slot == 5'h08) nxt_s.abort = s_ff.sdaSync;
              if (s_ff.slot > 5'h08 && s_ff.slot < 5'h11)
                nxt_s.shift = {s_ff.shift[6:0], s_ff.sdaSync};
            end
            default: begin
              nxt_s.sclOe = 1'b1;
              nxt_s.slot = 5'(s_ff.slot + 5'h01);
              if (s_ff.slot == 5'h11 || (s_ff.slot == 5'h08 && s_ff.abort))
                nxt_s.st = ST_STOP;
            end
          endcase
        end
        ST_STOP: begin
          if (s_ff.phase == 2'h0) nxt_s.sdaOe = 1'b1;
          if (s_ff.phase == 2'h1) nxt_s.sclOe = 1'b0;
          if (s_ff.phase == 2'h2) nxt_s.sdaOe = 1'b0;
          if (s_ff.phase == 2'h3) begin
            nxt_s.st = ST_DONE;
            nxt_s.done = 1'b1;
            nxt_s.strobe = !s_ff.abort;
          end
        end
        default: nxt_s.st = ST_DONE;
      endcase
    end
    if (!reset_n) begin
      nxt_s = '0;
      nxt_s.st = ST_STRAP;
    end
  end
  always_ff @(posedge clk_sys) begin
    s_ff <= nxt_s;
  end
  assign sclOe = s_ff.sclOe;
  assign sdaOe = s_ff.sdaOe;
  assign rom.loadDone = s_ff.done;
  assign rom.loadStrobe = s_ff.strobe;
  assign rom.loadByte = s_ff.shift;
endmodule

/* File: tb/i2c_rom_model.sv */
/*
 Behavioural serial ROM on the two-wire bus: answers a current-address
 single-byte read at the block's ROM device address.
 Assumes open-drain lines resolved by the bench with pull-ups.
*/
`timescale 1ns/1ps
module i2c_rom_model
  import pm_cap_pkg::*;
#(
  parameter logic [7:0] ROM_BYTE = 8'h83
) (
  input wire logic scl,
  input wire logic sda,
  output logic sdaPullLow
);
  int bitCnt;
  logic active;
  logic addrOk;
  logic [7:0] shiftIn;

  initial begin
    sdaPullLow = 1'b0;
    active = 1'b0;
    addrOk = 1'b0;
    bitCnt = 0;
    shiftIn = 8'h00;
  end

  // Start and stop conditions
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      addrOk = 1'b0;
      // The start's own clock fall is not a bit
      bitCnt = -1;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (active && bitCnt < 8) begin
      shiftIn = {shiftIn[6:0], sda};
    end
  end

  // Changes only while the clock line is low; released otherwise
  always @(negedge scl) begin
    if (active) begin
      bitCnt = bitCnt + 1;
      sdaPullLow = 1'b0;
      if (bitCnt == 8 && shiftIn == {ROM_DEV_ADDR, 1'b1}) begin
        addrOk = 1'b1;
        sdaPullLow = 1'b1;
      end else if (addrOk && bitCnt >= 9 && bitCnt <= 16) begin
        sdaPullLow = ~ROM_BYTE[16 - bitCnt];
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
/*
 Self-checking bench of the power management capability block.
 Assumes the config request/acknowledge handshake and a shortened quarter-bit time.
*/
`timescale 1ns/1ps
module tb_top;
  import pm_cap_pkg::*;
  localparam int QTR = 4;
  logic clk_sys, reset_n, cfgReq, cfgWrite, cfgRetry, cfgAck;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWriteData, cfgReadData;
  logic identOverwriteEnable, resumeSeenFlag, wakeSignalOut, globalSuspend;
  logic romPresentPin, sclOe, sdaOe, romPullLow, sclOut, sdaOut;
  int err_total = 0;
  int comparisons = 0;
  wire sclLine = ~sclOe;
  wire sdaLine = ~(sdaOe | romPullLow);

  pm_capability #(.QUARTER(QTR)) i_pm_capability (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
    .cfgRetry(cfgRetry), .cfgAck(cfgAck), .cfgReadData(cfgReadData),
    .identOverwriteEnable(identOverwriteEnable), .resumeSeenFlag(resumeSeenFlag),
    .wakeSignalOut(wakeSignalOut), .globalSuspend(globalSuspend),
    .romPresentPin(romPresentPin), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe)
  );

  i2c_rom_model #(.ROM_BYTE(8'h83)) i_i2c_rom_model (
    .scl(sclLine), .sda(sdaLine), .sdaPullLow(romPullLow)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One config transfer; the request is dropped at the edge that takes it
  task automatic cfg(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic busy;
    int n;
    busy = 1'b1;
    n = 0;
    @(posedge clk_sys);
    cfgReq <= 1'b1;
    cfgWrite <= wr;
    cfgAddr <= addr;
    cfgByteEn <= be;
    cfgWriteData <= wd;
    while (busy && n < 5000) begin
      #1;
      busy = cfgRetry;
      @(posedge clk_sys);
      n++;
    end
    cfgReq <= 1'b0;
    #1;
    check({31'h0, cfgAck}, 32'h1);
    rd = cfgReadData;
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    cfg(1'b0, addr, 4'hf, 32'h0, v);
    check(v, exp);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] v;
    cfg(1'b1, addr, be, d, v);
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask

  task automatic resume_pulse();
    @(posedge clk_sys);
    resumeSeenFlag <= 1'b1;
    repeat (2) @(posedge clk_sys);
    resumeSeenFlag <= 1'b0;
    #1;
  endtask

  task automatic set_overwrite(input logic v);
    @(posedge clk_sys);
    identOverwriteEnable <= v;
  endtask

  initial begin
    reset_n = 1'b0;
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 8'h00;
    cfgByteEn = 4'h0;
    cfgWriteData = 32'h0;
    identOverwriteEnable = 1'b0;
    resumeSeenFlag = 1'b0;
    romPresentPin = 1'b0;
    do_reset();
    rdchk(8'h40, 32'h7e02_0001);
    rdchk(8'h44, 32'h0000_0000);
    rdchk(8'h48, 32'h0000_0000);
    wr(8'h40, 4'hf, 32'hffff_ffff);
    rdchk(8'h40, 32'h7e02_0001);
    set_overwrite(1'b1);
    wr(8'h40, 4'hc, 32'h7fff_0000);
    rdchk(8'h40, 32'h7e02_0001);
    wr(8'h40, 4'hf, 32'hffff_ffff);
    rdchk(8'h40, 32'hffc2_0001);
    set_overwrite(1'b0);
    for (int s = 3; s >= 0; s--) begin
      wr(8'h44, 4'h1, 32'(s));
      rdchk(8'h44, 32'(s));
      check({31'h0, globalSuspend}, {31'h0, s != 0});
    end
    resume_pulse();
    check({31'h0, wakeSignalOut}, 32'h0);
    rdchk(8'h44, 32'h0000_8000);
    wr(8'h44, 4'h3, 32'h0000_0100);
    rdchk(8'h44, 32'h0000_8100);
    check({31'h0, wakeSignalOut}, 32'h1);
    wr(8'h44, 4'h2, 32'h0000_8100);
    rdchk(8'h44, 32'h0000_0100);
    check({31'h0, wakeSignalOut}, 32'h0);
    resume_pulse();
    @(posedge clk_sys);
    romPresentPin <= 1'b1;
    do_reset();
    #1;
    check({31'h0, wakeSignalOut}, 32'h1);
    @(posedge clk_sys);
    cfgReq <= 1'b1;
    cfgWrite <= 1'b0;
    cfgAddr <= 8'h44;
    #1;
    check({31'h0, cfgRetry}, 32'h1);
    rdchk(8'h44, 32'h0000_8100);
    rdchk(8'h40, 32'hfec2_0001);
    check({28'h0, sclOut, sdaOut, sclOe, sdaOe}, 32'h0);
    set_overwrite(1'b1);
    wr(8'h40, 4'h8, 32'h0000_0000);
    rdchk(8'h40, 32'h7e02_0001);
    @(posedge clk_sys);
    romPresentPin <= 1'b0;
    do_reset();
    rdchk(8'h44, 32'h0000_0000);
    check({31'h0, wakeSignalOut}, 32'h0);
    print_verdict();
  end

  // Whole run needs under a thousand cycles; this allows about twenty thousand
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
